// File: hdl/rsbm_pkg.sv
// Constants and types for the shared buffer memory map
// ===========================================================
// Operation
// [RULE1] Words 40..50 report the eleven configured point counts in fixed order.
// [RULE2] Words 51..54 hold the IPv4 address, first octet at 51.
// [RULE3] IPv4 words read zero while no valid address is held.
// [RULE4] Words 55..62 hold the IPv6 address, word 1 at 55.
// [RULE5] Input groups: controller reads and writes, remote master only reads.
// [RULE6] Output groups: remote master reads and writes, controller only reads.
// [RULE7] Binary inputs pack sixteen points per word.
// [RULE8] Double binary inputs use two bits per point, eight per word.
// [RULE9] 16-bit words, 32-bit double words and floats for numeric groups.
// [RULE10] Input area starts at 1024, 512-word value section plus flag section.
// [RULE11] Flag sections are sized from each type's maximum point count.
// [RULE12] Controller stopped: input point flags show offline. Own points (first 16 binary inputs) still read 0x0101.
// [RULE13] First binary word comes from module inputs; controller cannot write it.
// [RULE14] Flag bit b0 is device-owned: set on write, cleared on stop or loss.
// [RULE15] Single-word writes for 16-bit sections, double-word for 32-bit ones.
// [RULE16] Output area starts at 16384 with 512-word sections and sized flags.
// [RULE17] Controller stopped: output flags read offline instead of stored ones.
// [RULE18] Words 40..62 are device status; writes do not change them.
package rsbm_pkg;

  // ===========================================================
  // Status words
  localparam logic [14:0] RSBM_COUNT_BINARY_INPUTS = 15'h0028;
  localparam logic [14:0] RSBM_COUNT_DOUBLE_BINARY_INPUTS = 15'h0029;
  localparam logic [14:0] RSBM_COUNT_COUNTERS_16 = 15'h002a;
  localparam logic [14:0] RSBM_COUNT_COUNTERS_32 = 15'h002b;
  localparam logic [14:0] RSBM_COUNT_ANALOG_IN_16 = 15'h002c;
  localparam logic [14:0] RSBM_COUNT_ANALOG_IN_32 = 15'h002d;
  localparam logic [14:0] RSBM_COUNT_ANALOG_IN_FLOAT = 15'h002e;
  localparam logic [14:0] RSBM_COUNT_BINARY_OUTPUTS = 15'h002f;
  localparam logic [14:0] RSBM_COUNT_ANALOG_OUT_16 = 15'h0030;
  localparam logic [14:0] RSBM_COUNT_ANALOG_OUT_32 = 15'h0031;
  localparam logic [14:0] RSBM_COUNT_ANALOG_OUT_FLOAT = 15'h0032;
  localparam logic [14:0] RSBM_IPV4_OCTET_1 = 15'h0033;
  localparam logic [14:0] RSBM_IPV4_OCTET_2 = 15'h0034;
  localparam logic [14:0] RSBM_IPV4_OCTET_3 = 15'h0035;
  localparam logic [14:0] RSBM_IPV4_OCTET_4 = 15'h0036;
  localparam logic [14:0] RSBM_IPV6_WORD_1 = 15'h0037;
  localparam logic [14:0] RSBM_IPV6_WORD_2 = 15'h0038;
  localparam logic [14:0] RSBM_IPV6_WORD_3 = 15'h0039;
  localparam logic [14:0] RSBM_IPV6_WORD_4 = 15'h003a;
  localparam logic [14:0] RSBM_IPV6_WORD_5 = 15'h003b;
  localparam logic [14:0] RSBM_IPV6_WORD_6 = 15'h003c;
  localparam logic [14:0] RSBM_IPV6_WORD_7 = 15'h003d;
  localparam logic [14:0] RSBM_IPV6_WORD_8 = 15'h003e;
  localparam int RSBM_STAT_WORDS = 23;
  localparam int RSBM_COUNT_WORDS = 11;

  // ===========================================================
  // Protocol areas
  localparam logic [14:0] RSBM_IN_AREA = 15'h0400;
  localparam logic [14:0] RSBM_OUT_AREA = 15'h4000;
  localparam logic [14:0] RSBM_SEC_WORDS = 15'h0200;
  localparam int RSBM_IN_SECS = 7;
  localparam int RSBM_OUT_SECS = 4;
  localparam int RSBM_IN_BANK = 7680;
  localparam int RSBM_OUT_BANK = 8192;
  localparam int RSBM_SEEN_BITS = 15360;
  localparam logic [11:0] RSBM_OWN_FLAG_WORDS = 12'h008;
  localparam logic [15:0] RSBM_FLAGS_ONLINE = 16'h0101;

  typedef enum logic [1:0] {
    RSBM_K_BIN = 2'b00,
    RSBM_K_DBIN = 2'b01,
    RSBM_K_W16 = 2'b10,
    RSBM_K_W32 = 2'b11
  } rsbm_kind_e;

  localparam logic [14:0] RSBM_IN_BASE [RSBM_IN_SECS] =
    '{15'h0400, 15'h1600, 15'h2000, 15'h2300, 15'h2580, 15'h2880, 15'h2b00};
  localparam logic [14:0] RSBM_IN_FLAGW [RSBM_IN_SECS] =
    '{15'h1000, 15'h0800, 15'h0100, 15'h0080, 15'h0100, 15'h0080, 15'h0080};
  localparam rsbm_kind_e RSBM_IN_KIND [RSBM_IN_SECS] =
    '{RSBM_K_BIN, RSBM_K_DBIN, RSBM_K_W16, RSBM_K_W32, RSBM_K_W16, RSBM_K_W32, RSBM_K_W32};
  localparam logic [14:0] RSBM_OUT_BASE [RSBM_OUT_SECS] =
    '{15'h4000, 15'h5200, 15'h5700, 15'h5b80};
  localparam logic [14:0] RSBM_OUT_FLAGW [RSBM_OUT_SECS] =
    '{15'h1000, 15'h0100, 15'h0080, 15'h0080};
  localparam rsbm_kind_e RSBM_OUT_KIND [RSBM_OUT_SECS] =
    '{RSBM_K_BIN, RSBM_K_W16, RSBM_K_W32, RSBM_K_W32};

  typedef struct packed {
    logic hit;
    logic out;
    logic [2:0] sec;
    logic flag;
    logic [11:0] off;
  } rsbm_dec_s;

  typedef struct packed {
    logic [15:0] din_s1;
    logic [15:0] din_s2;
    logic [15:0] din_s3;
    logic [15:0] din_q;
    logic [2:0] run_s;
    logic run_q;
    logic [2:0] comm_s;
    logic comm_q;
    logic [RSBM_STAT_WORDS-1:0][15:0] stat;
    logic [31:0] ctl_rdata;
    logic ctl_ack;
    logic ctl_refused;
    logic [15:0] rm_rdata;
    logic rm_ack;
    logic rm_refused;
    logic offline;
  } rsbm_state_s;

  localparam rsbm_state_s RSBM_RST_STATE = '{offline: 1'b1, default: '0};

endpackage

// File: hdl/rsbm_top.sv
// Shared buffer memory: status words, input and output protocol areas
`timescale 1ns/1ns
module rsbm_top
  import rsbm_pkg::*;
#(
  parameter int DIN_W = 2
)(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ctl_rd_i,
  input wire logic ctl_wr_i,
  input wire logic ctl_dword_i,
  input wire logic [14:0] ctl_addr_i,
  input wire logic [31:0] ctl_wdata_i,
  output logic [31:0] ctl_rdata_o,
  output logic ctl_ack_o,
  output logic ctl_refused_o,
  input wire logic rm_rd_i,
  input wire logic rm_wr_i,
  input wire logic [14:0] rm_addr_i,
  input wire logic [15:0] rm_wdata_i,
  output logic [15:0] rm_rdata_o,
  output logic rm_ack_o,
  output logic rm_refused_o,
  input wire logic [RSBM_COUNT_WORDS*16-1:0] cfg_counts_i,
  input wire logic [31:0] ipv4_addr_i,
  input wire logic ipv4_valid_i,
  input wire logic [127:0] ipv6_addr_i,
  input wire logic plc_run_i,
  input wire logic plc_comm_ok_i,
  input wire logic [DIN_W-1:0] din_i,
  output logic plc_offline_o
);

  // ===========================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_pipe <= 2'h0;
    else
      rst_pipe <= {rst_pipe[0], 1'b1};
  end

  assign rst_n = rst_pipe[1];

  // ===========================================================
  // Storage
  // Banked by address parity so a double word lands in one cycle
  logic [15:0] in_ev [0:RSBM_IN_BANK-1];
  logic [15:0] in_od [0:RSBM_IN_BANK-1];
  logic [15:0] out_ev [0:RSBM_OUT_BANK-1];
  logic [15:0] out_od [0:RSBM_OUT_BANK-1];
  logic [RSBM_SEEN_BITS-1:0] seen;

  rsbm_state_s s;
  rsbm_state_s next_s;
  logic online;
  logic ctl_we;
  logic rm_we;
  logic ctl_val_wr;
  logic [13:0] ctl_idx;
  logic [13:0] rm_idx;

  assign online = s.run_q & s.comm_q;
  assign ctl_idx = 14'(ctl_addr_i - RSBM_IN_AREA);
  assign rm_idx = rm_addr_i[13:0];

  // ===========================================================
  // Address decode
  function automatic rsbm_dec_s decode(input logic [14:0] a);
    rsbm_dec_s d;
    d = '0;
    // Sections sit at fixed places whatever the configured counts
    for (int i = 0; i < RSBM_IN_SECS; i++)
    begin
      if (a >= RSBM_IN_BASE[i] && a < RSBM_IN_BASE[i] + RSBM_SEC_WORDS)
      begin
        d.hit = 1'b1;
        d.sec = 3'(i);
        d.off = 12'(a - RSBM_IN_BASE[i]);
      end
      // [RULE10] [RULE11] Value then flag section
      else if (a >= RSBM_IN_BASE[i] + RSBM_SEC_WORDS &&
               a < RSBM_IN_BASE[i] + RSBM_SEC_WORDS + RSBM_IN_FLAGW[i])
      begin
        d.hit = 1'b1;
        d.sec = 3'(i);
        d.flag = 1'b1;
        d.off = 12'(a - RSBM_IN_BASE[i] - RSBM_SEC_WORDS);
      end
    end
    for (int i = 0; i < RSBM_OUT_SECS; i++)
    begin
      // [RULE16] Output sections
      if (a >= RSBM_OUT_BASE[i] && a < RSBM_OUT_BASE[i] + RSBM_SEC_WORDS)
      begin
        d.hit = 1'b1;
        d.out = 1'b1;
        d.sec = 3'(i);
        d.off = 12'(a - RSBM_OUT_BASE[i]);
      end
      else if (a >= RSBM_OUT_BASE[i] + RSBM_SEC_WORDS &&
               a < RSBM_OUT_BASE[i] + RSBM_SEC_WORDS + RSBM_OUT_FLAGW[i])
      begin
        d.hit = 1'b1;
        d.out = 1'b1;
        d.sec = 3'(i);
        d.flag = 1'b1;
        d.off = 12'(a - RSBM_OUT_BASE[i] - RSBM_SEC_WORDS);
      end
    end
    return d;
  endfunction

  // ===========================================================
  // Point to value word
  // One flag byte per point; the value word holding the point decides b0
  function automatic logic [13:0] point_word(input logic [2:0] sec, input logic [12:0] p);
    logic [13:0] base;
    logic [13:0] w;
    base = 14'(RSBM_IN_BASE[sec] - RSBM_IN_AREA);
    case (RSBM_IN_KIND[sec])
      // [RULE7] Sixteen points a word
      RSBM_K_BIN: w = base + 14'(p[12:4]);
      // [RULE8] Two bits a point
      RSBM_K_DBIN: w = base + 14'(p[12:3]);
      // [RULE9] One word per 16-bit point
      RSBM_K_W16: w = base + 14'(p);
      // [RULE9] Two words per 32-bit or float point
      RSBM_K_W32: w = base + 14'({p, 1'b0});
      default: w = base;
    endcase
    return w;
  endfunction

  function automatic logic flag_b0(input logic [2:0] sec, input logic [12:0] p);
    logic [13:0] w;
    w = point_word(sec, p);
    // [RULE12] [RULE14] Offline once stopped or lost, valid after a write
    return online & seen[w];
  endfunction

  // ===========================================================
  // Word read
  function automatic logic [15:0] read_word(input logic [14:0] a);
    rsbm_dec_s d;
    logic [13:0] i;
    logic [15:0] w;
    d = decode(a);
    i = 14'(a - RSBM_IN_AREA);
    w = 16'h0000;
    if (a >= RSBM_COUNT_BINARY_INPUTS && a <= RSBM_IPV6_WORD_8)
      // [RULE18] Status from device registers only
      w = s.stat[5'(a - RSBM_COUNT_BINARY_INPUTS)];
    else if (a == RSBM_IN_AREA)
      // [RULE13] Module's own inputs
      w = s.din_q;
    else if (d.hit && !d.out)
    begin
      w = i[0] ? in_od[i[13:1]] : in_ev[i[13:1]];
      if (d.flag)
      begin
        w[0] = flag_b0(d.sec, {d.off, 1'b0});
        w[8] = flag_b0(d.sec, {d.off, 1'b1});
        // [RULE13] Own points always online and valid
        if (d.sec == 3'h0 && d.off < RSBM_OWN_FLAG_WORDS)
          w = RSBM_FLAGS_ONLINE;
      end
    end
    else if (d.hit)
    begin
      w = a[0] ? out_od[a[13:1]] : out_ev[a[13:1]];
      // [RULE17] Stored flags give way to offline
      if (d.flag && !online)
        w = 16'h0000;
    end
    return w;
  endfunction

  // ===========================================================
  // Write acceptance
  function automatic logic ctl_may_write(input logic [14:0] a, input logic dw);
    rsbm_dec_s d;
    logic ok;
    d = decode(a);
    // [RULE5] [RULE6] Controller writes input groups only
    ok = d.hit & ~d.out;
    // [RULE13] Module input word and its flags are closed
    if (a == RSBM_IN_AREA)
      ok = 1'b0;
    if (d.flag && d.sec == 3'h0 && d.off < RSBM_OWN_FLAG_WORDS)
      ok = 1'b0;
    // [RULE15] Word width must match the section
    if (!d.flag && RSBM_IN_KIND[d.sec] == RSBM_K_W32)
    begin
      if (!dw || a[0])
        ok = 1'b0;
    end
    else if (dw)
      ok = 1'b0;
    return ok;
  endfunction

  function automatic logic ctl_hits_value(input logic [14:0] a);
    rsbm_dec_s d;
    d = decode(a);
    return d.hit & ~d.out & ~d.flag;
  endfunction

  function automatic logic rm_may_write(input logic [14:0] a);
    rsbm_dec_s d;
    d = decode(a);
    // [RULE5] [RULE6] Remote master writes output groups only
    return d.hit & d.out;
  endfunction

  assign ctl_we = ctl_wr_i & ctl_may_write(ctl_addr_i, ctl_dword_i);
  assign ctl_val_wr = ctl_we & ctl_hits_value(ctl_addr_i);
  assign rm_we = rm_wr_i & rm_may_write(rm_addr_i);

  // ===========================================================
  // Memory write ports
  always_ff @(posedge clk_sys_i)
  begin
    if (ctl_we)
    begin
      if (ctl_dword_i)
      begin
        in_ev[ctl_idx[13:1]] <= ctl_wdata_i[15:0];
        in_od[ctl_idx[13:1]] <= ctl_wdata_i[31:16];
      end
      else if (ctl_idx[0])
        in_od[ctl_idx[13:1]] <= ctl_wdata_i[15:0];
      else
        in_ev[ctl_idx[13:1]] <= ctl_wdata_i[15:0];
    end
    if (rm_we)
    begin
      if (rm_idx[0])
        out_od[rm_idx[13:1]] <= rm_wdata_i;
      else
        out_ev[rm_idx[13:1]] <= rm_wdata_i;
    end
  end

  // ===========================================================
  // Written-since-online map
  // Wiped as a whole while offline, so no point keeps a stale valid flag
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      seen <= '0;
    else
    begin
      // [RULE14] Stop or loss clears b0
      if (!online)
        seen <= '0;
      // [RULE14] Value write sets b0, winning over a clear
      if (ctl_val_wr)
      begin
        seen[ctl_idx] <= 1'b1;
        if (ctl_dword_i)
          seen[14'(ctl_idx + 14'h0001)] <= 1'b1;
      end
    end
  end

  // ===========================================================
  // Next state
  always_comb
  begin
    next_s = s;
    next_s.din_s1 = 16'(din_i);
    next_s.din_s2 = s.din_s1;
    next_s.din_s3 = s.din_s2;
    // Accept a level once the last two stages agree
    next_s.din_q = (~(s.din_s2 ^ s.din_s3) & s.din_s3) | ((s.din_s2 ^ s.din_s3) & s.din_q);
    next_s.run_s = {s.run_s[1:0], plc_run_i};
    if (s.run_s[1] == s.run_s[2])
      next_s.run_q = s.run_s[2];
    next_s.comm_s = {s.comm_s[1:0], plc_comm_ok_i};
    if (s.comm_s[1] == s.comm_s[2])
      next_s.comm_q = s.comm_s[2];
    next_s.offline = ~(next_s.run_q & next_s.comm_q);

    // [RULE1] Configured counts in fixed order
    for (int k = 0; k < RSBM_COUNT_WORDS; k++)
      next_s.stat[k] = cfg_counts_i[k*16 +: 16];
    // [RULE2] [RULE3] Octets, zero while no valid address is held
    for (int k = 0; k < 4; k++)
      next_s.stat[RSBM_COUNT_WORDS + k] =
        ipv4_valid_i ? {8'h00, ipv4_addr_i[31-8*k -: 8]} : 16'h0000;
    // [RULE4] Most significant word first
    for (int k = 0; k < 8; k++)
      next_s.stat[RSBM_COUNT_WORDS + 4 + k] = ipv6_addr_i[127-16*k -: 16];

    // Controller answers one cycle after the request
    next_s.ctl_ack = ctl_rd_i | ctl_wr_i;
    next_s.ctl_refused = ctl_wr_i & ~ctl_we;
    if (ctl_rd_i)
    begin
      next_s.ctl_rdata[15:0] = read_word(ctl_addr_i);
      // [RULE9] Double word: low half at the lower address
      next_s.ctl_rdata[31:16] =
        ctl_dword_i ? read_word(15'(ctl_addr_i + 15'h0001)) : 16'h0000;
    end

    next_s.rm_ack = rm_rd_i | rm_wr_i;
    next_s.rm_refused = rm_wr_i & ~rm_we;
    if (rm_rd_i)
      next_s.rm_rdata = read_word(rm_addr_i);
  end

  // ===========================================================
  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      s <= RSBM_RST_STATE;
    else
      s <= next_s;
  end

  // ===========================================================
  // Outputs
  assign ctl_rdata_o = s.ctl_rdata;
  assign ctl_ack_o = s.ctl_ack;
  assign ctl_refused_o = s.ctl_refused;
  assign rm_rdata_o = s.rm_rdata;
  assign rm_ack_o = s.rm_ack;
  assign rm_refused_o = s.rm_refused;
  assign plc_offline_o = s.offline;

endmodule

// File: test/rsbm_assertions.sv
// Port checker for the shared buffer memory
`timescale 1ns/1ns
module rsbm_assertions
  import rsbm_pkg::*;
#(
  parameter int DIN_W = 2
)(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ctl_rd_i,
  input wire logic ctl_wr_i,
  input wire logic ctl_dword_i,
  input wire logic [14:0] ctl_addr_i,
  input wire logic [31:0] ctl_rdata_o,
  input wire logic ctl_ack_o,
  input wire logic ctl_refused_o,
  input wire logic rm_wr_i,
  input wire logic rm_rd_i,
  input wire logic [14:0] rm_addr_i,
  input wire logic rm_ack_o,
  input wire logic rm_refused_o,
  input wire logic [RSBM_COUNT_WORDS*16-1:0] cfg_counts_i,
  input wire logic ipv4_valid_i,
  input wire logic plc_run_i,
  input wire logic plc_offline_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // ===========================================================
  // Bus answers
  a_ctl_ack_next: assert property ((ctl_rd_i || ctl_wr_i) |=> ctl_ack_o)
    else $error("controller request not answered");
  a_ctl_ack_cause: assert property (ctl_ack_o |-> $past(ctl_rd_i) || $past(ctl_wr_i))
    else $error("controller answer without request");
  a_rm_ack_next: assert property ((rm_rd_i || rm_wr_i) |=> rm_ack_o)
    else $error("remote request not answered");
  // ===========================================================
  // Write permissions
  a_rm_in_ro: assert property (rm_wr_i && rm_addr_i < 15'h4000 |=> rm_refused_o)
    else $error("remote write to input area taken");
  a_ctl_out_ro: assert property (ctl_wr_i && ctl_addr_i >= 15'h4000 |=> ctl_refused_o)
    else $error("controller write to output area taken");
  a_stat_ro: assert property (ctl_wr_i && ctl_addr_i inside {[15'h0028:15'h003e]}
    |=> ctl_refused_o) else $error("status word write taken");
  a_own_word_ro: assert property (ctl_wr_i && ctl_addr_i == 15'h0400 |=> ctl_refused_o)
    else $error("own input word write taken");
  a_dword_only: assert property (ctl_wr_i && !ctl_dword_i
    && ctl_addr_i inside {[15'h2300:15'h24ff]} |=> ctl_refused_o)
    else $error("single write to 32-bit section taken");
  // ===========================================================
  // Status and offline
  a_ipv4_zero: assert property (ctl_rd_i && ctl_addr_i == 15'h0033 && !ipv4_valid_i
    && !$past(ipv4_valid_i) |=> ctl_rdata_o == 32'h0) else $error("invalid address not zero");
  a_count_word: assert property (ctl_rd_i && !ctl_dword_i && ctl_addr_i == 15'h0028
    && $stable(cfg_counts_i) |=> ctl_rdata_o == {16'h0, $past(cfg_counts_i[15:0])})
    else $error("count word mismatch");
  a_offline_stop: assert property (!plc_run_i [*8] |-> plc_offline_o)
    else $error("stopped controller not offline");
  c_ctl_refused: cover property (ctl_ack_o && ctl_refused_o);
  c_rm_write: cover property (rm_wr_i ##1 rm_ack_o);
  c_offline_read: cover property (plc_offline_o && ctl_rd_i);
endmodule
bind rsbm_top rsbm_assertions #(.DIN_W(DIN_W)) i_chk (.clk_sys_i, .rst_n_i, .ctl_rd_i,
  .ctl_wr_i, .ctl_dword_i, .ctl_addr_i, .ctl_rdata_o, .ctl_ack_o, .ctl_refused_o, .rm_wr_i,
  .rm_rd_i, .rm_addr_i, .rm_ack_o, .rm_refused_o, .cfg_counts_i, .ipv4_valid_i, .plc_run_i,
  .plc_offline_o);

// File: test/rsbm_plc_model.sv
// Controller model on the expansion bus side
`timescale 1ns/1ns
module rsbm_plc_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic ref_i,
  input wire logic [31:0] rdata_i,
  output logic rd_o,
  output logic wr_o,
  output logic dw_o,
  output logic [14:0] addr_o,
  output logic [31:0] wdata_o
);
  initial
  begin
    rd_o = 1'b0;
    wr_o = 1'b0;
    dw_o = 1'b0;
    addr_o = 15'h7fff;
    wdata_o = 32'h0;
  end
  task automatic acc(input logic rd, input logic wr, input logic dw, input logic [14:0] a,
    input logic [31:0] d, output logic ack, output logic rf, output logic [31:0] q);
    @(posedge clk_i);
    rd_o <= rd;
    wr_o <= wr;
    dw_o <= dw;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    rd_o <= 1'b0;
    wr_o <= 1'b0;
    // Released lines must not keep old values
    addr_o <= ~a;
    wdata_o <= ~d;
    @(posedge clk_i);
    ack = ack_i;
    rf = ref_i;
    q = rdata_i;
  endtask
endmodule

// File: test/rtu_shared_buffer_map_tb_top.sv
// Testbench for the shared buffer memory
`timescale 1ns/1ns
module rtu_shared_buffer_map_tb_top
  import rsbm_pkg::*;
;
  logic clk_sys_i, rst_n_i, rm_rd_i, rm_wr_i, ipv4_valid_i, plc_run_i, plc_comm_ok_i;
  logic ctl_rd_i, ctl_wr_i, ctl_dword_i, ctl_ack_o, ctl_refused_o, rm_ack_o, rm_refused_o;
  logic plc_offline_o, ack, rf;
  logic [14:0] ctl_addr_i, rm_addr_i;
  logic [31:0] ctl_wdata_i, ctl_rdata_o, ipv4_addr_i, q;
  logic [15:0] rm_wdata_i, rm_rdata_o;
  logic [RSBM_COUNT_WORDS*16-1:0] cfg_counts_i;
  logic [127:0] ipv6_addr_i;
  logic [1:0] din_i;
  int num_errors = 0;
  int n_checks = 0;
  rsbm_top #(.DIN_W(2)) i_dut (.clk_sys_i, .rst_n_i, .ctl_rd_i, .ctl_wr_i, .ctl_dword_i,
    .ctl_addr_i, .ctl_wdata_i, .ctl_rdata_o, .ctl_ack_o, .ctl_refused_o, .rm_rd_i, .rm_wr_i,
    .rm_addr_i, .rm_wdata_i, .rm_rdata_o, .rm_ack_o, .rm_refused_o, .cfg_counts_i,
    .ipv4_addr_i, .ipv4_valid_i, .ipv6_addr_i, .plc_run_i, .plc_comm_ok_i, .din_i,
    .plc_offline_o);
  rsbm_plc_model i_plc (.clk_i(clk_sys_i), .ack_i(ctl_ack_o), .ref_i(ctl_refused_o),
    .rdata_i(ctl_rdata_o), .rd_o(ctl_rd_i), .wr_o(ctl_wr_i), .dw_o(ctl_dword_i),
    .addr_o(ctl_addr_i), .wdata_o(ctl_wdata_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // ===========================================================
  // Tasks
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cw(input logic [14:0] a, input logic [31:0] d, input logic dw, input logic xr);
    i_plc.acc(1'b0, 1'b1, dw, a, d, ack, rf, q);
    chk({31'h0, ack, rf}, {31'h0, 1'b1, xr});
  endtask
  task automatic cr(input logic [14:0] a, input logic dw, input logic [31:0] m,
    input logic [31:0] x);
    i_plc.acc(1'b1, 1'b0, dw, a, 32'h0, ack, rf, q);
    chk({ack, q & m}, {1'b1, x});
  endtask
  task automatic rm(input logic wr, input logic [14:0] a, input logic [15:0] d,
    input logic xr, input logic [15:0] x);
    @(posedge clk_sys_i);
    rm_rd_i <= !wr;
    rm_wr_i <= wr;
    rm_addr_i <= a;
    rm_wdata_i <= d;
    @(posedge clk_sys_i);
    rm_rd_i <= 1'b0;
    rm_wr_i <= 1'b0;
    rm_addr_i <= ~a;
    @(posedge clk_sys_i);
    chk({15'h0, rm_ack_o, rm_refused_o, wr ? 16'h0 : rm_rdata_o}, {15'h0, 1'b1, xr, x});
  endtask
  function automatic logic [31:0] exp_stat(input int k);
    if (k < 11)
      return {16'h0, cfg_counts_i[16*k +: 16]};
    if (k < 15)
      return {24'h0, ipv4_addr_i[8*(14-k) +: 8]};
    return {16'h0, ipv6_addr_i[16*(22-k) +: 16]};
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ===========================================================
  // Sequence
  initial
  begin
    rst_n_i = 1'b0;
    rm_rd_i = 1'b0;
    rm_wr_i = 1'b0;
    rm_addr_i = 15'h0;
    rm_wdata_i = 16'h0;
    for (int k = 0; k < 11; k++)
      cfg_counts_i[16*k +: 16] = 16'h0100 + 16'(k);
    ipv4_addr_i = 32'hc0a8_0a05;
    ipv6_addr_i = 128'h2001_0db8_0000_0011_0022_0033_0044_0055;
    ipv4_valid_i = 1'b1;
    plc_run_i = 1'b1;
    plc_comm_ok_i = 1'b1;
    din_i = 2'b10;
    repeat (3) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    // Sync stages need settling before first request
    repeat (8) @(posedge clk_sys_i);
    for (int k = 0; k < 23; k++)
      cr(15'h0028 + 15'(k), 1'b0, 32'hffff_ffff, exp_stat(k));
    cw(15'h0028, 32'h0000_7777, 1'b0, 1'b1);
    cr(15'h0028, 1'b0, 32'hffff_ffff, 32'h0000_0100);
    ipv4_valid_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    cr(15'h0033, 1'b0, 32'hffff_ffff, 32'h0);
    cr(15'h0400, 1'b0, 32'hffff_ffff, 32'h0000_0002);
    cw(15'h0400, 32'h0000_ffff, 1'b0, 1'b1);
    cr(15'h0600, 1'b0, 32'hffff_ffff, 32'h0000_0101);
    cw(15'h0401, 32'h0000_a5c3, 1'b0, 1'b0);
    cr(15'h0401, 1'b0, 32'hffff_ffff, 32'h0000_a5c3);
    rm(1'b0, 15'h0401, 16'h0, 1'b0, 16'ha5c3);
    rm(1'b1, 15'h0401, 16'h1111, 1'b1, 16'h0);
    cr(15'h0608, 1'b0, 32'h0000_0101, 32'h0000_0101);
    cw(15'h1601, 32'h0000_e41b, 1'b0, 1'b0);
    cr(15'h1601, 1'b0, 32'hffff_ffff, 32'h0000_e41b);
    cw(15'h1fff, 32'h0000_3c00, 1'b0, 1'b0);
    cr(15'h1fff, 1'b0, 32'h0000_fefe, 32'h0000_3c00);
    cw(15'h2300, 32'h0000_1234, 1'b0, 1'b1);
    cw(15'h2300, 32'h89ab_cdef, 1'b1, 1'b0);
    cr(15'h2300, 1'b1, 32'hffff_ffff, 32'h89ab_cdef);
    cw(15'h2301, 32'h0000_0001, 1'b1, 1'b1);
    rm(1'b1, 15'h4000, 16'h5a5a, 1'b0, 16'h0);
    cr(15'h4000, 1'b0, 32'hffff_ffff, 32'h0000_5a5a);
    cw(15'h4000, 32'h0000_0001, 1'b0, 1'b1);
    rm(1'b1, 15'h4200, 16'h0101, 1'b0, 16'h0);
    cr(15'h4200, 1'b0, 32'hffff_ffff, 32'h0000_0101);
    rm(1'b1, 15'h5200, 16'h7e7e, 1'b0, 16'h0);
    rm(1'b0, 15'h5200, 16'h0, 1'b0, 16'h7e7e);
    plc_run_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk({32'h0, plc_offline_o}, {32'h0, 1'b1});
    cr(15'h0608, 1'b0, 32'h0000_0101, 32'h0);
    cr(15'h0600, 1'b0, 32'hffff_ffff, 32'h0000_0101);
    cr(15'h4200, 1'b0, 32'hffff_ffff, 32'h0);
    rm(1'b0, 15'h4200, 16'h0, 1'b0, 16'h0);
    plc_run_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    chk({32'h0, plc_offline_o}, {32'h0, 1'b0});
    cr(15'h0608, 1'b0, 32'h0000_0101, 32'h0);
    cw(15'h0401, 32'h0000_0f0f, 1'b0, 1'b0);
    cr(15'h0608, 1'b0, 32'h0000_0101, 32'h0000_0101);
    plc_comm_ok_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    chk({32'h0, plc_offline_o}, {32'h0, 1'b1});
    cr(15'h0608, 1'b0, 32'h0000_0101, 32'h0);
    final_report;
  end
  // Run needs about two hundred cycles; this is ample
  initial
  begin
    #20000;
    num_errors++;
    final_report;
  end
endmodule
